//--- verilog/wdtt_pkg.sv
// wdtt_pkg: constants, register map and carrier types for the two-stage watchdog.
// assumes a 32-bit classic wishbone slave port and one 20 MHz clock.
// Overview of operation
// - 32-bit down counter with a programmable load register supplying the reload value.
// - once enabled, counter reaching zero is the first timeout and raises the interrupt.
// - setting the counter enable also turns on the interrupt enable.
// - at first timeout reload the counter and keep counting down.
// - second zero with interrupt uncleared and reset enabled asserts system reset.
// - if interrupt cleared before second timeout, reload and resume counting.
// - writing the load register while running loads the counter at once.
// - once locked, writes changing configuration, enables included, are ignored.
// - an interrupt-clear write deasserts the timeout interrupt source.
// - status readable raw or masked by interrupt enable, one meaning active.
// - a reload value of zero generates the timeout interrupt immediately.
// - with stall set, counter freezes while the processor is debug-halted.
// - a control enables reset on second timeout; ignored while locked.
package wdtt_pkg;

  localparam int unsigned WDTT_DW = 32;
  localparam int unsigned WDTT_AW = 8;

  // register byte offsets
  localparam logic [WDTT_AW-1:0] WDTT_OFF_LOAD   = 8'h00;
  localparam logic [WDTT_AW-1:0] WDTT_OFF_VALUE  = 8'h04;
  localparam logic [WDTT_AW-1:0] WDTT_OFF_CTRL   = 8'h08;
  localparam logic [WDTT_AW-1:0] WDTT_OFF_ICLR   = 8'h0C;
  localparam logic [WDTT_AW-1:0] WDTT_OFF_RIS    = 8'h10;
  localparam logic [WDTT_AW-1:0] WDTT_OFF_MIS    = 8'h14;
  localparam logic [WDTT_AW-1:0] WDTT_OFF_LOCK   = 8'h18;

  // control bit positions
  localparam int unsigned WDTT_CTRL_INTEN = 0;
  localparam int unsigned WDTT_CTRL_RESEN = 1;
  localparam int unsigned WDTT_CTRL_STALL = 2;

  localparam logic [WDTT_DW-1:0] WDTT_LOAD_RST   = 32'hFFFF_FFFF;
  localparam logic [WDTT_DW-1:0] WDTT_UNLOCK_KEY = 32'h1ACC_E551;
  localparam logic [WDTT_DW-1:0] WDTT_ZERO       = 32'h0000_0000;
  localparam logic [WDTT_DW-1:0] WDTT_ONE        = 32'h0000_0001;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [3:0]        sel;
    logic [WDTT_AW-1:0] adr;
    logic [WDTT_DW-1:0] dat;
  } wdtt_wb_req_s;

  typedef struct packed {
    logic              ack;
    logic [WDTT_DW-1:0] dat;
  } wdtt_wb_rsp_s;

endpackage : wdtt_pkg

//--- verilog/wdtt_sync.sv
// wdtt_sync: two-flop synchroniser for one level from outside the clock domain.
// assumes clk_i is the block clock; stage one is read only by stage two.
`timescale 1ns/100ps
module wdtt_sync
  import wdtt_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb
  begin
    meta_d = ce_i ? d_i : meta_q;
    sync_d = ce_i ? meta_q : sync_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;
endmodule : wdtt_sync

//--- verilog/wdtt_top.sv
// wdtt_top: two-stage watchdog with wishbone registers, interrupt and reset request.
// assumes a classic wishbone master on clk_i; dbg_halt_i comes from another domain.
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
module wdtt_top
  import wdtt_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [WDTT_AW-1:0] adr_i,
  input  wire logic [WDTT_DW-1:0] dat_i,
  output logic      [WDTT_DW-1:0] dat_o,
  output logic                    ack_o,
  input  wire logic               dbg_halt_i,
  output logic                    irq_o,
  output logic                    sys_rst_o
);

  wdtt_wb_req_s req;
  logic         halt_s;

  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};

  wdtt_sync u_halt_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (dbg_halt_i),
    .q_o   (halt_s)
  );

  // state
  logic [WDTT_DW-1:0] load_q,  load_d;
  logic [WDTT_DW-1:0] cnt_q,   cnt_d;
  logic               run_q,   run_d;
  logic               inten_q, inten_d;
  logic               resen_q, resen_d;
  logic               stall_q, stall_d;
  logic               lock_q,  lock_d;
  logic               ris_q,   ris_d;
  logic               srst_q,  srst_d;
  logic               zload_q, zload_d;
  logic               ack_q,   ack_d;
  logic [WDTT_DW-1:0] rdat_q,  rdat_d;
  logic               irq_q,   irq_d;

  logic               acc;
  logic               wr;
  logic [WDTT_DW-1:0] wmask;
  logic [WDTT_DW-1:0] wval;
  logic               wr_load;
  logic               wr_ctrl;
  logic               wr_iclr;
  logic               wr_lock;
  logic               ticking;
  logic               at_zero;

  // one-cycle ack; a held request is taken again every second cycle, ack dropping in between
  assign acc = req.cyc & req.stb & ~ack_q;
  assign wr  = acc & req.we;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      wmask[i*8 +: 8] = {8{req.sel[i]}};
  end

  assign wval    = req.dat & wmask;
  assign wr_load = wr & (req.adr == WDTT_OFF_LOAD) & ~lock_q;
  assign wr_ctrl = wr & (req.adr == WDTT_OFF_CTRL) & ~lock_q;
  // clear stays open while locked, or a handler could never acknowledge
  assign wr_iclr = wr & (req.adr == WDTT_OFF_ICLR);
  assign wr_lock = wr & (req.adr == WDTT_OFF_LOCK);

  // halt is seen two clocks late, so a stall starts and ends that much after the pin
  assign ticking = run_q & ~(stall_q & halt_s);
  assign at_zero = ticking & (cnt_q == WDTT_ZERO);

  // counter, configuration and timeout state
  always_comb
  begin
    load_d  = load_q;
    cnt_d   = cnt_q;
    run_d   = run_q;
    inten_d = inten_q;
    resen_d = resen_q;
    stall_d = stall_q;
    lock_d  = lock_q;
    ris_d   = ris_q;
    srst_d  = srst_q;
    zload_d = 1'b0;
    if (ticking)
    begin
      if (at_zero)
      begin
        cnt_d = load_q;
      end
      else
      begin
        cnt_d = cnt_q - WDTT_ONE;
      end
    end
    if (wr_iclr)
    begin
      ris_d = 1'b0;
    end
    if (at_zero)
    begin
      // a timeout in the clear cycle wins over the clear
      if (ris_q & resen_q)
      begin
        srst_d = 1'b1;
      end
      ris_d = 1'b1;
    end
    if (wr_ctrl)
    begin
      if (wval[WDTT_CTRL_INTEN])
      begin
        run_d   = 1'b1;
        inten_d = 1'b1;
      end
      resen_d = wval[WDTT_CTRL_RESEN];
      stall_d = wval[WDTT_CTRL_STALL];
    end
    if (wr_load)
    begin
      load_d = wval;
      cnt_d  = wval;
      zload_d = (wval == WDTT_ZERO);
    end
    // zero load raises status one clock after the write, even when stopped
    if (zload_q)
    begin
      ris_d = 1'b1;
    end
    if (wr_lock)
    begin
      lock_d = (wval != WDTT_UNLOCK_KEY);
    end
    irq_d = ris_d & inten_d;
  end

  // read mux
  always_comb
  begin
    ack_d  = acc;
    rdat_d = WDTT_ZERO;
    if (acc & ~req.we)
    begin
      case (req.adr)
        WDTT_OFF_LOAD:  rdat_d = load_q;
        WDTT_OFF_VALUE: rdat_d = cnt_q;
        WDTT_OFF_CTRL:
        begin
          rdat_d[WDTT_CTRL_INTEN] = inten_q;
          rdat_d[WDTT_CTRL_RESEN] = resen_q;
          rdat_d[WDTT_CTRL_STALL] = stall_q;
        end
        WDTT_OFF_RIS:   rdat_d[0] = ris_q;
        WDTT_OFF_MIS:   rdat_d[0] = ris_q & inten_q;
        WDTT_OFF_LOCK:  rdat_d[0] = lock_q;
        default:        rdat_d = WDTT_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      load_q  <= WDTT_LOAD_RST;
      cnt_q   <= WDTT_LOAD_RST;
      run_q   <= 1'b0;
      inten_q <= 1'b0;
      resen_q <= 1'b0;
      stall_q <= 1'b0;
      lock_q  <= 1'b0;
      ris_q   <= 1'b0;
      srst_q  <= 1'b0;
      zload_q <= 1'b0;
      ack_q   <= 1'b0;
      rdat_q  <= WDTT_ZERO;
      irq_q   <= 1'b0;
    end
    else if (ce_i)
    begin
      load_q  <= load_d;
      cnt_q   <= cnt_d;
      run_q   <= run_d;
      inten_q <= inten_d;
      resen_q <= resen_d;
      stall_q <= stall_d;
      lock_q  <= lock_d;
      ris_q   <= ris_d;
      srst_q  <= srst_d;
      zload_q <= zload_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
      irq_q   <= irq_d;
    end
  end

  assign dat_o     = rdat_q;
  assign ack_o     = ack_q;
  assign irq_o     = irq_q;
  assign sys_rst_o = srst_q;

  // checks
  chk_first_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && at_zero) |=> ris_q)
    else $error("first timeout did not set status");

  chk_enable_ties_int: assert property (@(posedge clk_i) disable iff (rst_i)
    run_q |-> inten_q)
    else $error("counter running without interrupt enable");

  chk_reload_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && at_zero && !wr_load) |=> (cnt_q == $past(load_q)))
    else $error("counter not reloaded at zero");

  chk_second_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && at_zero && ris_q && resen_q) |=> sys_rst_o)
    else $error("second timeout did not assert reset");

  chk_load_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_load) |=> (cnt_q == $past(wval)))
    else $error("load write not taken by counter");

  chk_lock_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    (lock_q && !wr_lock) |=> $stable(load_q) && $stable(resen_q))
    else $error("configuration changed while locked");

  chk_int_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_iclr && !at_zero && !zload_q) |=> !ris_q)
    else $error("interrupt clear ignored");

  chk_zero_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_load && wval == WDTT_ZERO) ##1 ce_i |=> ris_q)
    else $error("zero load gave no interrupt");

  chk_stall_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && stall_q && halt_s && !wr_load) |=> $stable(cnt_q))
    else $error("counter moved while stalled");

  chk_count_down: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && ticking && !at_zero && !wr_load) |=> (cnt_q == $past(cnt_q) - WDTT_ONE))
    else $error("counter did not decrement by one");

  // every load also sets the counter, so it never sits above the load value
  chk_count_in_range: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_q <= load_q)
    else $error("counter above load value");

  chk_first_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && at_zero && inten_q) |=> irq_o)
    else $error("timeout raised no interrupt");

  chk_enable_sets_both: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_ctrl && wval[WDTT_CTRL_INTEN]) |=> (run_q && inten_q))
    else $error("enable write left counter or interrupt off");

  chk_reset_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    sys_rst_o |=> sys_rst_o)
    else $error("reset request dropped");

  chk_clear_no_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && at_zero && !ris_q && !srst_q) |=> !sys_rst_o)
    else $error("reset after cleared interrupt");

  chk_lock_ctrl: assert property (@(posedge clk_i) disable iff (rst_i)
    (lock_q && !wr_lock) |=> ($stable(run_q) && $stable(inten_q) && $stable(stall_q)))
    else $error("control changed while locked");

  chk_unlock_key: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_lock && wval == WDTT_UNLOCK_KEY) |=> !lock_q)
    else $error("key did not unlock");

  chk_raw_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && acc && !req.we && req.adr == WDTT_OFF_RIS) |=> (dat_o[0] == $past(ris_q)))
    else $error("raw status read wrong");

  chk_masked_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && acc && !req.we && req.adr == WDTT_OFF_MIS) |=> (dat_o[0] == $past(ris_q && inten_q)))
    else $error("masked status read wrong");

  chk_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> inten_q)
    else $error("interrupt without enable");

  chk_stall_release: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && stall_q && ticking && !at_zero && !wr_load) |=> !$stable(cnt_q))
    else $error("counter did not resume after halt");

  chk_reset_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && at_zero && !resen_q && !srst_q) |=> !sys_rst_o)
    else $error("reset while reset disabled");

  chk_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> ($stable(cnt_q) && $stable(ris_q) && $stable(ack_o)))
    else $error("state moved with clock enable low");

endmodule : wdtt_top

//--- tb/wdtt_host.sv
// wdtt_host: far-side model that counts interrupt requests and catches the reset request.
// assumes irq and reset request are registered levels on clk_i.
`timescale 1ns/100ps
module wdtt_host (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic irq_i,
  input  wire logic sys_rst_i,
  output int        irq_cnt_o,
  output logic      rst_seen_o
);
  logic irq_q;
  always_ff @(posedge clk_i)
  begin
    irq_q      <= rst_i ? 1'b0 : irq_i;
    irq_cnt_o  <= rst_i ? 0 : irq_cnt_o + int'(irq_i & ~irq_q);
    rst_seen_o <= rst_i ? 1'b0 : (rst_seen_o | sys_rst_i);
  end
endmodule : wdtt_host

//--- tb/wdtt_top_tb.sv
// wdtt_top_tb: self-checking bench, wishbone master plus a small reference model.
// assumes one 20 MHz clock and a synchronous active-high reset.
`timescale 1ns/100ps
module wdtt_top_tb;
  import wdtt_pkg::*;
  logic               clk_i, rst_i, cyc, stb, we, halt, irq, srst, ack, rseen;
  logic               ce;
  logic [3:0]         sel;
  logic [WDTT_AW-1:0] adr;
  logic [WDTT_DW-1:0] wdat, rdat, r, r2;
  int                 errors, checked, cyc_n, t_ack, t1, seed, load_m, icnt, k;

  wdtt_top u_wdtt_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .sel_i(sel), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .dbg_halt_i(halt), .irq_o(irq),
    .sys_rst_o(srst));
  wdtt_host u_wdtt_host (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .sys_rst_i(srst), .irq_cnt_o(icnt),
    .rst_seen_o(rseen));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic conclude();
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000)
    begin
      errors++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; the extra edge keeps cyc low before the next request
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    r     = rdat;
    t_ack = cyc_n;
    cyc  <= 1'b0;
    stb  <= 1'b0;
    we   <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wait_irq(input logic lvl);
    k = 0;
    while (irq !== lvl && k < 3000)
    begin
      @(posedge clk_i);
      k++;
    end
  endtask : wait_irq

  initial
  begin
    seed = 76;
    errors = 0;
    checked = 0;
    cyc_n = 0;
    rst_i = 1'b1;
    {cyc, stb, we, halt, adr, wdat} = '0;
    ce = 1'b1;
    sel = 4'hF;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, WDTT_OFF_LOAD, 0); chk(r, WDTT_LOAD_RST);
    wb(0, WDTT_OFF_VALUE, 0); chk(r, WDTT_LOAD_RST);
    wb(0, 8'h1c, 0); chk(r, 0);
    wb(1, WDTT_OFF_VALUE, 32'h1234_5678);
    wb(0, WDTT_OFF_VALUE, 0); chk(r, WDTT_LOAD_RST);
    load_m = 40 + ($random(seed) & 15);
    wb(1, WDTT_OFF_LOAD, load_m);
    wb(0, WDTT_OFF_LOAD, 0); chk(r, load_m);
    wb(1, WDTT_OFF_CTRL, 32'h0000_0003);
    wait_irq(1); chk(k >= load_m - 5 && k <= load_m + 4, 1);
    wb(0, WDTT_OFF_RIS, 0); chk(r, 1);
    wb(0, WDTT_OFF_MIS, 0); chk(r, 1);
    wb(0, WDTT_OFF_VALUE, 0); chk(r <= load_m && r + 20 > load_m, 1);
    r2 = r;
    t1 = t_ack;
    wb(0, WDTT_OFF_VALUE, 0); chk(r2 - r, t_ack - t1);
    wb(1, WDTT_OFF_ICLR, $random(seed));
    wait_irq(0); chk(k <= 3, 1);
    wb(0, WDTT_OFF_RIS, 0); chk(r, 0);
    wait_irq(1); chk(k <= load_m, 1);
    chk({31'h0, srst}, 0);
    // the host counts a rising edge one clock after it
    @(posedge clk_i);
    chk(icnt, 2);
    wb(1, WDTT_OFF_ICLR, 0);
    wb(1, WDTT_OFF_LOAD, 32'h0000_0400);
    wb(0, WDTT_OFF_VALUE, 0); chk(r <= 32'h0000_0400 && r >= 32'h0000_03f0, 1);
    wb(1, WDTT_OFF_CTRL, 32'h0000_0007);
    halt <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(0, WDTT_OFF_VALUE, 0);
    r2 = r;
    wb(0, WDTT_OFF_VALUE, 0); chk(r, r2);
    halt <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(0, WDTT_OFF_VALUE, 0); chk(r < r2, 1);
    // ten frozen clocks between two reads must not count
    r2 = r;
    ce <= 1'b0;
    repeat (10) @(posedge clk_i);
    ce <= 1'b1;
    wb(0, WDTT_OFF_VALUE, 0); chk(r2 - r, 3);
    wb(1, WDTT_OFF_LOCK, 0);
    wb(0, WDTT_OFF_LOCK, 0); chk(r, 1);
    wb(1, WDTT_OFF_LOAD, 32'h0000_0005);
    wb(0, WDTT_OFF_LOAD, 0); chk(r, 32'h0000_0400);
    wb(1, WDTT_OFF_CTRL, 32'h0000_0001);
    wb(0, WDTT_OFF_CTRL, 0); chk(r, 32'h0000_0007);
    wb(1, WDTT_OFF_LOCK, WDTT_UNLOCK_KEY);
    wb(0, WDTT_OFF_LOCK, 0); chk(r, 0);
    wb(1, WDTT_OFF_CTRL, 32'h0000_0001);
    wb(0, WDTT_OFF_CTRL, 0); chk(r, 32'h0000_0001);
    wb(1, WDTT_OFF_ICLR, 0);
    // only the low byte selected: the upper bytes write as zero, a zero load
    sel <= 4'h1;
    wb(1, WDTT_OFF_LOAD, 32'hFFFF_FF00);
    sel <= 4'hF;
    wait_irq(1); chk(k <= 4, 1);
    wb(0, WDTT_OFF_LOAD, 0); chk(r, WDTT_ZERO);
    repeat (8) @(posedge clk_i);
    chk({31'h0, srst}, 0);
    // reload first so that enabling reset does not meet a pending zero
    wb(1, WDTT_OFF_LOAD, load_m);
    wb(1, WDTT_OFF_ICLR, 0);
    wb(1, WDTT_OFF_CTRL, 32'h0000_0003);
    wait_irq(1); chk(k <= load_m, 1);
    k = 0;
    while (srst !== 1'b1 && k < 3000)
    begin
      @(posedge clk_i);
      k++;
    end
    chk(k >= load_m - 3 && k <= load_m + 3, 1);
    @(posedge clk_i);
    chk({31'h0, rseen}, 1);
    chk(icnt, 4);
    // mid-run reset must drop the sticky request and restore the load value
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, srst}, 0);
    chk({31'h0, irq}, 0);
    wb(0, WDTT_OFF_LOAD, 0); chk(r, WDTT_LOAD_RST);
    conclude();
  end
endmodule : wdtt_top_tb
